/* core/irq_bank_if.sv */
`timescale 1ns/1ns

interface irq_bank_if
(
   input wire logic clk,
   input wire logic sys_rst
);

   irq_bank_pkg::dev_addr_type reg_addr;
   irq_bank_pkg::byte_type     reg_wdata;
   logic                       reg_wr;
   logic                       reg_rd;
   irq_bank_pkg::byte_type     reg_rdata;
   logic                       global_irq_enable;
   logic                       peripheral_group_enable;
   logic                       peripheral_irq_request;

   modport device
   (
      input  clk,
      input  sys_rst,
      input  reg_addr,
      input  reg_wdata,
      input  reg_wr,
      input  reg_rd,
      input  global_irq_enable,
      input  peripheral_group_enable,
      output reg_rdata,
      output peripheral_irq_request
   );

   modport host
   (
      input  clk,
      input  sys_rst,
      output reg_addr,
      output reg_wdata,
      output reg_wr,
      output reg_rd,
      output global_irq_enable,
      output peripheral_group_enable,
      input  reg_rdata,
      input  peripheral_irq_request
   );

endinterface : irq_bank_if

/* core/irq_bank_pkg.sv */
package irq_bank_pkg;

   typedef logic [7:0] byte_type;
   typedef logic [1:0] dev_addr_type;

   typedef enum logic [1:0]
   {
      CAPCMP_CAPTURE,
      CAPCMP_COMPARE,
      CAPCMP_PWM
   } capcmp_mode_type;

endpackage : irq_bank_pkg

/* core/irq_bank_regs.svh */
`ifndef IRQ_BANK_REGS_SVH
`define IRQ_BANK_REGS_SVH

// ----------------------------------------------------------------
// Device register indices
// ----------------------------------------------------------------
`define IDX_ENABLE_SECOND      2'h0
`define IDX_ENABLE_THIRD       2'h1
`define IDX_REQUEST_FIRST      2'h2

// ----------------------------------------------------------------
// Implemented bit masks
// ----------------------------------------------------------------
`define MASK_ENABLE_SECOND     8'hFD
`define MASK_ENABLE_THIRD      8'h7A
`define MASK_REQUEST_STICKY    8'h4F

// ----------------------------------------------------------------
// Request register bit positions
// ----------------------------------------------------------------
`define BIT_TIMER_ONE_GATE     7
`define BIT_CONVERTER_DONE     6
`define BIT_SERIAL_RX_FULL     5
`define BIT_SERIAL_TX_EMPTY    4
`define BIT_SYNC_PORT_DONE     3
`define BIT_CAPCMP_ONE         2
`define BIT_TIMER_TWO_MATCH    1
`define BIT_TIMER_ONE_OVERFLOW 0

// ----------------------------------------------------------------
// Core control bit positions
// ----------------------------------------------------------------
`define BIT_GLOBAL_IRQ_ENABLE  7
`define BIT_PERIPH_GROUP_EN    6

// ----------------------------------------------------------------
// Controller register offsets
// ----------------------------------------------------------------
`define OFF_CORE_CONTROL       4'h0
`define OFF_IRQ_STATUS         4'h1
`define OFF_IRQ_CLEAR          4'h2
`define OFF_IRQ_ENABLE         4'h3
`define OFF_DEVICE_WINDOW      4'h8

// ----------------------------------------------------------------
// Controller status bits
// ----------------------------------------------------------------
`define BIT_EVT_REQ_RISE       0
`define BIT_EVT_REQ_FALL       1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE               8'h00

`endif

/* core/irq_core_ctrl.sv */
`timescale 1ns/1ns
`include "irq_bank_regs.svh"

module irq_core_ctrl
#(
   parameter int ADDR_W = 4
)
(
   irq_bank_if.host                   bus,
   input  wire logic [ADDR_W-1:0]     sw_addr,
   input  wire irq_bank_pkg::byte_type sw_wdata,
   input  wire logic                  sw_wr,
   input  wire logic                  sw_rd,
   output irq_bank_pkg::byte_type     sw_rdata,
   output logic                       core_interrupt,
   output logic                       irq
);

   if (ADDR_W < 4)
   begin : g_addr_check
      $error("ADDR_W must be at least 4");
   end

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   irq_bank_pkg::byte_type core_interrupt_control;
   irq_bank_pkg::byte_type irq_status;
   irq_bank_pkg::byte_type irq_enable;
   irq_bank_pkg::byte_type own_rdata;
   logic                   device_read;
   logic                   request_seen;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire logic [3:0] low_addr;
   wire logic       upper_zero;
   wire logic       hit_window;
   wire logic       hit_control;
   wire logic       hit_status;
   wire logic       hit_clear;
   wire logic       hit_enable;

   assign low_addr    = sw_addr[3:0];
   assign upper_zero  = (sw_addr >> 4) == '0;
   // Whole window goes to the device, which reads its empty index as zero
   assign hit_window  = upper_zero & (low_addr[3:2] == 2'h2);
   assign hit_control = upper_zero & (low_addr == `OFF_CORE_CONTROL);
   assign hit_status  = upper_zero & (low_addr == `OFF_IRQ_STATUS);
   assign hit_clear   = upper_zero & (low_addr == `OFF_IRQ_CLEAR);
   assign hit_enable  = upper_zero & (low_addr == `OFF_IRQ_ENABLE);

   // Device window forwards the access in the same cycle
   assign bus.reg_addr  = low_addr[1:0];
   assign bus.reg_wdata = sw_wdata;
   assign bus.reg_wr    = sw_wr & hit_window;
   assign bus.reg_rd    = sw_rd & hit_window;

   assign bus.global_irq_enable       =
      core_interrupt_control[`BIT_GLOBAL_IRQ_ENABLE];
   assign bus.peripheral_group_enable =
      core_interrupt_control[`BIT_PERIPH_GROUP_EN];

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   irq_bank_pkg::byte_type events;
   irq_bank_pkg::byte_type next_status;
   irq_bank_pkg::byte_type next_own_rdata;

   always_comb
   begin
      events = `RST_BYTE;
      events[`BIT_EVT_REQ_RISE] = bus.peripheral_irq_request
                                & ~request_seen;
      events[`BIT_EVT_REQ_FALL] = ~bus.peripheral_irq_request
                                & request_seen;
   end

   // Set wins over a clear in the same cycle
   assign next_status = (irq_status & ~(hit_clear & sw_wr
                                        ? sw_wdata : `RST_BYTE))
                      | events;

   assign next_own_rdata =
        hit_control ? core_interrupt_control
      : hit_status  ? irq_status
      : hit_enable  ? irq_enable
      : `RST_BYTE;

   always_ff @(posedge bus.clk)
   begin
      if (bus.sys_rst)
      begin
         core_interrupt_control <= `RST_BYTE;
         irq_enable             <= `RST_BYTE;
         irq_status             <= `RST_BYTE;
         request_seen           <= 1'b0;
      end
      else
      begin
         if (sw_wr & hit_control)
         begin
            core_interrupt_control <= sw_wdata;
         end
         if (sw_wr & hit_enable)
         begin
            irq_enable <= sw_wdata;
         end
         irq_status   <= next_status;
         request_seen <= bus.peripheral_irq_request;
      end
   end

   always_ff @(posedge bus.clk)
   begin
      if (bus.sys_rst)
      begin
         own_rdata   <= `RST_BYTE;
         device_read <= 1'b0;
      end
      else
      begin
         own_rdata   <= sw_rd ? next_own_rdata : `RST_BYTE;
         device_read <= sw_rd & hit_window;
      end
   end

   assign sw_rdata       = device_read ? bus.reg_rdata : own_rdata;
   assign core_interrupt = request_seen;
   assign irq            = |(irq_status & irq_enable);

endmodule : irq_core_ctrl

/* core/irq_flag_bank.sv */
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "irq_bank_regs.svh"

module irq_flag_bank
(
   irq_bank_if.device                 bus,
   input  wire logic                  timer_one_gate_active,
   input  wire logic                  converter_done,
   input  wire logic                  serial_rx_full,
   input  wire logic                  serial_tx_empty,
   input  wire logic                  sync_port_done,
   input  wire logic                  capcmp_one_event,
   input  wire irq_bank_pkg::capcmp_mode_type capcmp_one_mode,
   input  wire logic                  timer_two_match,
   input  wire logic                  timer_one_overflow,
   input  wire irq_bank_pkg::byte_type first_enable,
   input  wire irq_bank_pkg::byte_type second_request,
   input  wire irq_bank_pkg::byte_type third_request,
   output irq_bank_pkg::byte_type     enable_second_bits,
   output irq_bank_pkg::byte_type     enable_third_bits,
   output irq_bank_pkg::byte_type     request_first_bits
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   irq_bank_pkg::byte_type peripheral_enable_second;
   irq_bank_pkg::byte_type peripheral_enable_third;
   irq_bank_pkg::byte_type sticky_flags;
   irq_bank_pkg::byte_type read_data;
   logic                   request_out;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire logic hit_enable_second;
   wire logic hit_enable_third;
   wire logic hit_request_first;
   wire logic wr_enable_second;
   wire logic wr_enable_third;
   wire logic wr_request_first;

   assign hit_enable_second = (bus.reg_addr == `IDX_ENABLE_SECOND);
   assign hit_enable_third  = (bus.reg_addr == `IDX_ENABLE_THIRD);
   assign hit_request_first = (bus.reg_addr == `IDX_REQUEST_FIRST);
   assign wr_enable_second  = bus.reg_wr & hit_enable_second;
   assign wr_enable_third   = bus.reg_wr & hit_enable_third;
   assign wr_request_first  = bus.reg_wr & hit_request_first;

   // ----------------------------------------------------------------
   // Event vector for the sticky flags
   // ----------------------------------------------------------------
   wire logic                   capcmp_one_counts;
   wire irq_bank_pkg::byte_type flag_events;

   assign capcmp_one_counts = capcmp_one_event
                            & (capcmp_one_mode != irq_bank_pkg::CAPCMP_PWM);

   assign flag_events = {1'b0,
                         converter_done,
                         1'b0,
                         1'b0,
                         sync_port_done,
                         capcmp_one_counts,
                         timer_two_match,
                         timer_one_overflow};

   // ----------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------
   irq_bank_pkg::byte_type next_enable_second;
   irq_bank_pkg::byte_type next_enable_third;
   irq_bank_pkg::byte_type next_sticky_flags;
   irq_bank_pkg::byte_type sticky_written;

   assign next_enable_second = wr_enable_second
                             ? (bus.reg_wdata & `MASK_ENABLE_SECOND)
                             : peripheral_enable_second;

   assign next_enable_third = wr_enable_third
                            ? (bus.reg_wdata & `MASK_ENABLE_THIRD)
                            : peripheral_enable_third;

   assign sticky_written = wr_request_first
                         ? (bus.reg_wdata & `MASK_REQUEST_STICKY)
                         : sticky_flags;

   assign next_sticky_flags = sticky_written
                            | (flag_events & `MASK_REQUEST_STICKY);

   // ----------------------------------------------------------------
   // Request register view
   // ----------------------------------------------------------------
   irq_bank_pkg::byte_type request_first_view;

   always_comb
   begin
      request_first_view = sticky_flags;
      request_first_view[`BIT_TIMER_ONE_GATE]  = ~timer_one_gate_active;
      request_first_view[`BIT_SERIAL_RX_FULL]  = serial_rx_full;
      request_first_view[`BIT_SERIAL_TX_EMPTY] = serial_tx_empty;
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   irq_bank_pkg::byte_type next_read_data;

   assign next_read_data =
        hit_enable_second ? peripheral_enable_second
      : hit_enable_third  ? peripheral_enable_third
      : hit_request_first ? request_first_view
      : `RST_BYTE;

   // ----------------------------------------------------------------
   // Request toward the core
   // ----------------------------------------------------------------
   wire logic any_first;
   wire logic any_second;
   wire logic any_third;
   wire logic next_request;

   assign any_first  = |(request_first_view & first_enable);
   assign any_second = |(second_request & peripheral_enable_second);
   assign any_third  = |(third_request & peripheral_enable_third);

   assign next_request = (any_first | any_second | any_third)
                       & bus.peripheral_group_enable
                       & bus.global_irq_enable;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // enable reset to zero
   always_ff @(posedge bus.clk)
   begin
      if (bus.sys_rst)
      begin
         peripheral_enable_second <= `RST_BYTE;
         peripheral_enable_third  <= `RST_BYTE;
      end
      else
      begin
         peripheral_enable_second <= next_enable_second;
         peripheral_enable_third  <= next_enable_third;
      end
   end

   always_ff @(posedge bus.clk)
   begin
      if (bus.sys_rst)
      begin
         sticky_flags <= `RST_BYTE;
      end
      else
      begin
         sticky_flags <= next_sticky_flags;
      end
   end

   always_ff @(posedge bus.clk)
   begin
      if (bus.sys_rst)
      begin
         read_data   <= `RST_BYTE;
         request_out <= 1'b0;
      end
      else
      begin
         if (bus.reg_rd)
         begin
            read_data <= next_read_data;
         end
         request_out <= next_request;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus.reg_rdata              = read_data;
   assign bus.peripheral_irq_request = request_out;
   assign enable_second_bits         = peripheral_enable_second;
   assign enable_third_bits          = peripheral_enable_third;
   assign request_first_bits         = request_first_view;

endmodule : irq_flag_bank

/* test/irq_bank_assertions.sv */
`timescale 1ns/1ns

// --------------------
// Interface checks
// --------------------
module irq_bank_assertions
(
   input wire logic                       clk,
   input wire logic                       sys_rst,
   input wire irq_bank_pkg::dev_addr_type reg_addr,
   input wire irq_bank_pkg::byte_type     reg_wdata,
   input wire logic                       reg_wr,
   input wire logic                       reg_rd,
   input wire irq_bank_pkg::byte_type     reg_rdata,
   input wire logic                       global_irq_enable,
   input wire logic                       peripheral_group_enable,
   input wire logic                       peripheral_irq_request
);

   default clocking dflt_cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   chk_group_blocks:
      assert property (!peripheral_group_enable |=> !peripheral_irq_request)
      else $error("request passed with group enable low");

   chk_global_blocks:
      assert property (!global_irq_enable |=> !peripheral_irq_request)
      else $error("request passed with global enable low");

   chk_rise_needs_enables:
      assert property ($rose(peripheral_irq_request) |->
         $past(global_irq_enable) && $past(peripheral_group_enable))
      else $error("request rose without both enables");

   chk_second_unimpl:
      assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata[1] == 1'b0)
      else $error("second enable bit 1 read nonzero");

   chk_third_unimpl:
      assert property (reg_rd && reg_addr == 2'h1 |=>
         (reg_rdata & 8'h85) == 8'h00)
      else $error("third enable unimplemented bits nonzero");

   chk_unmapped_zero:
      assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
      else $error("unmapped index read nonzero");

   chk_rdata_holds:
      assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   chk_second_readback:
      assert property (reg_wr && reg_addr == 2'h0 ##1
         reg_rd && reg_addr == 2'h0 |=>
         reg_rdata == ($past(reg_wdata, 2) & 8'hFD))
      else $error("second enable readback wrong");

   chk_third_readback:
      assert property (reg_wr && reg_addr == 2'h1 ##1
         reg_rd && reg_addr == 2'h1 |=>
         reg_rdata == ($past(reg_wdata, 2) & 8'h7A))
      else $error("third enable readback wrong");

endmodule : irq_bank_assertions

/* test/peripheral_irq_enable_flag_bank_bench.sv */
`timescale 1ns/1ns

module peripheral_irq_enable_flag_bank_bench;

   logic                        clk;
   logic                        sys_rst;
   logic [3:0]                  sw_addr;
   irq_bank_pkg::byte_type      sw_wdata;
   logic                        sw_wr;
   logic                        sw_rd;
   irq_bank_pkg::byte_type      sw_rdata;
   logic                        core_interrupt;
   logic                        irq;
   logic                        gate_active;
   logic [4:0]                  events;
   logic                        rx_full;
   logic                        tx_empty;
   irq_bank_pkg::capcmp_mode_type capcmp_mode;
   irq_bank_pkg::byte_type      first_enable;
   irq_bank_pkg::byte_type      second_request;
   irq_bank_pkg::byte_type      third_request;
   irq_bank_pkg::byte_type      en2;
   irq_bank_pkg::byte_type      en3;
   irq_bank_pkg::byte_type      req1;
   irq_bank_pkg::byte_type      masks [2] = '{8'hFD, 8'h7A};
   int                          n_fail = 0;
   int                          checked = 0;

   irq_bank_if i_irq_bank_if (.clk(clk), .sys_rst(sys_rst));

   irq_flag_bank i_irq_flag_bank
   (
      .bus                   (i_irq_bank_if),
      .timer_one_gate_active (gate_active),
      .converter_done        (events[4]),
      .serial_rx_full        (rx_full),
      .serial_tx_empty       (tx_empty),
      .sync_port_done        (events[3]),
      .capcmp_one_event      (events[2]),
      .capcmp_one_mode       (capcmp_mode),
      .timer_two_match       (events[1]),
      .timer_one_overflow    (events[0]),
      .first_enable          (first_enable),
      .second_request        (second_request),
      .third_request         (third_request),
      .enable_second_bits    (en2),
      .enable_third_bits     (en3),
      .request_first_bits    (req1)
   );

   irq_core_ctrl i_irq_core_ctrl
   (
      .bus            (i_irq_bank_if),
      .sw_addr        (sw_addr),
      .sw_wdata       (sw_wdata),
      .sw_wr          (sw_wr),
      .sw_rd          (sw_rd),
      .sw_rdata       (sw_rdata),
      .core_interrupt (core_interrupt),
      .irq            (irq)
   );

   irq_bank_assertions i_irq_bank_assertions
   (
      .clk                     (clk),
      .sys_rst                 (sys_rst),
      .reg_addr                (i_irq_bank_if.reg_addr),
      .reg_wdata               (i_irq_bank_if.reg_wdata),
      .reg_wr                  (i_irq_bank_if.reg_wr),
      .reg_rd                  (i_irq_bank_if.reg_rd),
      .reg_rdata               (i_irq_bank_if.reg_rdata),
      .global_irq_enable       (i_irq_bank_if.global_irq_enable),
      .peripheral_group_enable (i_irq_bank_if.peripheral_group_enable),
      .peripheral_irq_request  (i_irq_bank_if.peripheral_irq_request)
   );

   always #5 clk = ~clk;

   // --------------------
   // Access tasks
   // --------------------
   task automatic compare(input irq_bank_pkg::byte_type got,
                          input irq_bank_pkg::byte_type exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task automatic sw_write(input logic [3:0]             a,
                           input irq_bank_pkg::byte_type d);
      @(posedge clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge clk);
      sw_wr    <= 1'b0;
   endtask : sw_write

   task automatic sw_read(input logic [3:0]             a,
                          input irq_bank_pkg::byte_type e);
      @(posedge clk);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge clk);
      sw_rd   <= 1'b0;
      @(negedge clk);
      compare(sw_rdata, e);
   endtask : sw_read

   // Write then read at once
   task automatic rw(input logic [3:0] a, input irq_bank_pkg::byte_type d,
                     input irq_bank_pkg::byte_type e);
      sw_write(a, d);
      sw_rd    <= 1'b1;
      @(posedge clk);
      sw_rd    <= 1'b0;
      @(negedge clk);
      compare(sw_rdata, e);
   endtask : rw

   task automatic pulse(input logic [4:0] ev);
      @(posedge clk);
      events <= ev;
      @(posedge clk);
      events <= 5'h00;
      settle(1);
   endtask : pulse

   task automatic req_is(input logic v);
      compare({7'h00, i_irq_bank_if.peripheral_irq_request}, {7'h00, v});
   endtask : req_is

   task test_done;
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   // --------------------
   // Test sequence
   // --------------------
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      sw_addr = 4'h0;
      sw_wdata = 8'h00;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      gate_active = 1'b1;
      events = 5'h00;
      rx_full = 1'b0;
      tx_empty = 1'b0;
      capcmp_mode = irq_bank_pkg::CAPCMP_CAPTURE;
      first_enable = 8'h00;
      second_request = 8'h00;
      third_request = 8'h00;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      sw_read(4'h8, 8'h00);
      sw_read(4'h9, 8'h00);
      sw_read(4'hA, 8'h00);
      sw_read(4'h0, 8'h00);
      rw(4'h8, 8'hFF, 8'hFD);
      compare(en2, 8'hFD);
      rw(4'h9, 8'hFF, 8'h7A);
      compare(en3, 8'h7A);
      rw(4'h8, 8'h00, 8'h00);
      rw(4'h9, 8'h00, 8'h00);
      pulse(5'h1F);
      sw_read(4'hA, 8'h4F);
      req_is(1'b0);
      rw(4'hA, 8'h00, 8'h00);
      @(posedge clk);
      capcmp_mode <= irq_bank_pkg::CAPCMP_COMPARE;
      pulse(5'h04);
      sw_read(4'hA, 8'h04);
      rw(4'hA, 8'h00, 8'h00);
      @(posedge clk);
      capcmp_mode <= irq_bank_pkg::CAPCMP_PWM;
      pulse(5'h04);
      sw_read(4'hA, 8'h00);
      @(posedge clk);
      gate_active <= 1'b0;
      rx_full <= 1'b1;
      tx_empty <= 1'b1;
      rw(4'hA, 8'h00, 8'hB0);
      compare(req1, 8'hB0);
      @(posedge clk);
      gate_active <= 1'b1;
      rx_full <= 1'b0;
      tx_empty <= 1'b0;
      pulse(5'h01);
      sw_read(4'hA, 8'h01);
      @(posedge clk);
      first_enable <= 8'h01;
      for (int i = 0; i < 4; i++)
      begin
         sw_write(4'h0, {i[1:0], 6'h00});
         settle(2);
         req_is(i == 3);
      end
      compare({7'h00, core_interrupt}, 8'h01);
      @(posedge clk);
      first_enable <= 8'h00;
      settle(2);
      req_is(1'b0);
      sw_read(4'h1, 8'h03);
      compare({7'h00, irq}, 8'h00);
      sw_write(4'h3, 8'h01);
      settle(1);
      compare({7'h00, irq}, 8'h01);
      sw_write(4'h2, 8'h01);
      settle(1);
      compare({7'h00, irq}, 8'h00);
      sw_read(4'h1, 8'h02);
      sw_write(4'h3, 8'h00);
      sw_write(4'h5, 8'hFF);
      sw_read(4'h5, 8'h00);
      sw_read(4'hB, 8'h00);
      rw(4'hA, 8'h00, 8'h00);
      for (int r = 0; r < 2; r++)
         for (int i = 0; i < 8; i++)
         begin
            @(posedge clk);
            second_request <= (r == 0) ? (8'h01 << i) : 8'h00;
            third_request <= (r == 1) ? (8'h01 << i) : 8'h00;
            sw_write(r ? 4'h9 : 4'h8, 8'h01 << i);
            settle(2);
            req_is(masks[r][i]);
            sw_write(r ? 4'h9 : 4'h8, 8'h00);
            settle(2);
            req_is(1'b0);
         end
      sw_write(4'h8, 8'hFF);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      sw_read(4'h8, 8'h00);
      sw_read(4'h0, 8'h00);
      test_done();
   end

   initial
   begin
      #200000;
      n_fail++;
      test_done();
   end

endmodule : peripheral_irq_enable_flag_bank_bench
